// ---- ewp_host.sv ----
// host controller: unlock, page write and toggle poll to the eeprom
// Notes on behaviour
// - without polling wait full write time
// - three unlock bytes precede the first data write of each page
// - unlock bytes use page write spacing
// - byte writes spaced 0.5 to 100 us
// - address latched on falling latch strobe
// - one page holds 1 to 128 bytes
`default_nettype none
module ewp_host #(
  parameter int unsigned WC_CYCLES = ewp_pkg::WC_CYC,
  parameter int unsigned BLI_MAX = ewp_pkg::BLI_MAX_CYC,
  parameter bit USE_POLL = 1'b1
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // user request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [14:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic busy,
  // device pins
  output logic ale,
  output logic [14:8] addr_hi,
  output logic [7:0] ad_o,
  output logic ad_oe,
  input wire logic [7:0] ad_i,
  output logic rd_n,
  output logic wr_n,
  output logic ce_n,
  output logic program_fetch_strobe_n
);
  typedef enum {
    S_IDLE, S_ALE, S_ADR, S_STRB, S_HOLD, S_GAP, S_WAIT, S_POLL
  } ewp_state_t;
  ewp_state_t state_q;
  logic [31:0] cnt_q;
  logic [1:0] unl_q;
  logic in_page_q, page_last_q, cur_wr_q, cur_unl_q, poll_q, poll_first_q;
  logic [7:0] page_cnt_q;
  logic [14:0] cur_a_q;
  logic [7:0] cur_d_q;
  logic [7:0] ad_s1_q, ad_s2_q;
  logic tog_q;
  logic [31:0] gap_q;

  function automatic logic [14:0] unl_addr(input logic [1:0] i);
    unl_addr = (i == 2'd0) ? ewp_pkg::UNL_A0 :
               (i == 2'd1) ? ewp_pkg::UNL_A1 : ewp_pkg::UNL_A2;
  endfunction
  function automatic logic [7:0] unl_data(input logic [1:0] i);
    unl_data = (i == 2'd0) ? ewp_pkg::UNL_D0 :
               (i == 2'd1) ? ewp_pkg::UNL_D1 : ewp_pkg::UNL_D2;
  endfunction

  // read data pins pass two flops before use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ad_s1_q <= 8'h00;
      ad_s2_q <= 8'h00;
    end else if (clk_en) begin
      ad_s1_q <= ad_i;
      ad_s2_q <= ad_s1_q;
    end
  end

  // cycles since last write strobe fell, guards page spacing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // saturated: no write seen yet, so the first byte never waits
      gap_q <= 32'hFFFF_FFFF;
    end else if (clk_en) begin
      if (state_q == S_STRB && cur_wr_q && cnt_q == 32'h0000_0000) begin
        gap_q <= 32'h0000_0000;
      end else if (gap_q != 32'hFFFF_FFFF) begin
        gap_q <= gap_q + 32'h0000_0001;
      end
    end
  end

  // main sequencer: one bus cycle, then page and poll bookkeeping
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q <= 32'h0000_0000;
      unl_q <= 2'd0;
      in_page_q <= 1'b0;
      page_last_q <= 1'b0;
      cur_wr_q <= 1'b0;
      cur_unl_q <= 1'b0;
      poll_q <= 1'b0;
      poll_first_q <= 1'b0;
      page_cnt_q <= 8'h00;
      cur_a_q <= 15'h0000;
      cur_d_q <= 8'h00;
      tog_q <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      busy <= 1'b0;
      ale <= 1'b0;
      addr_hi <= 7'h00;
      ad_o <= 8'h00;
      ad_oe <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      ce_n <= 1'b1;
      program_fetch_strobe_n <= 1'b1;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      case (state_q)
        S_IDLE: begin
          busy <= in_page_q;
          if (req_valid && !req_ready) begin
            busy <= 1'b1;
            cur_wr_q <= req_write;
            cur_d_q <= req_data;
            cur_a_q <= req_addr;
            page_last_q <= req_last ||
              (page_cnt_q == 8'(ewp_pkg::PAGE_MAX - 1));
            if (req_write && !in_page_q) begin
              cur_unl_q <= 1'b1;
              unl_q <= 2'd0;
              cur_a_q <= unl_addr(2'd0);
              cur_d_q <= unl_data(2'd0);
            end else begin
              cur_unl_q <= 1'b0;
            end
            cnt_q <= 32'h0000_0000;
            ce_n <= 1'b0;
            state_q <= S_ALE;
          end else if (in_page_q && gap_q >= BLI_MAX - 32'd4) begin
            // user starved the page: let it program rather than break it
            in_page_q <= 1'b0;
            page_cnt_q <= 8'h00;
            cnt_q <= 32'h0000_0000;
            state_q <= USE_POLL ? S_POLL : S_WAIT;
            poll_first_q <= 1'b1;
          end
        end
        S_ALE: begin
          // address on pins while latch strobe is high
          ale <= 1'b1;
          addr_hi <= cur_a_q[14:8];
          ad_o <= cur_a_q[7:0];
          ad_oe <= 1'b1;
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q == 32'(ewp_pkg::PHASE_CYC - 1)) begin
            ale <= 1'b0;
            cnt_q <= 32'h0000_0000;
            state_q <= S_ADR;
          end
        end
        S_ADR: begin
          // address hold after latch fall
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q == 32'(ewp_pkg::PHASE_CYC - 1)) begin
            cnt_q <= 32'h0000_0000;
            ad_oe <= cur_wr_q || cur_unl_q;
            ad_o <= cur_d_q;
            state_q <= S_STRB;
          end
        end
        S_STRB: begin
          if (cur_wr_q || cur_unl_q) begin
            wr_n <= 1'b0;
          end else begin
            rd_n <= 1'b0;
          end
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q == 32'(ewp_pkg::PHASE_CYC)) begin
            // data stays driven past the rising write edge
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            rsp_data <= ad_s2_q;
            cnt_q <= 32'h0000_0000;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q == 32'(ewp_pkg::PHASE_CYC - 1)) begin
            ad_oe <= 1'b0;
            ce_n <= 1'b1;
            cnt_q <= 32'h0000_0000;
            state_q <= S_GAP;
          end
        end
        S_GAP: begin
          // every byte, unlock or data, keeps page spacing
          if (gap_q >= 32'(ewp_pkg::BLI_MIN_CYC) ||
              !(cur_wr_q || cur_unl_q)) begin
            if (poll_q) begin
              state_q <= S_POLL;
            end else if (cur_unl_q && unl_q != 2'd2) begin
              unl_q <= unl_q + 2'd1;
              cur_a_q <= unl_addr(unl_q + 2'd1);
              cur_d_q <= unl_data(unl_q + 2'd1);
              ce_n <= 1'b0;
              state_q <= S_ALE;
            end else if (cur_unl_q) begin
              // unlock done, now the data byte from the request
              cur_unl_q <= 1'b0;
              cur_a_q <= req_addr;
              cur_d_q <= req_data;
              in_page_q <= 1'b1;
              ce_n <= 1'b0;
              state_q <= S_ALE;
            end else if (cur_wr_q) begin
              req_ready <= 1'b1;
              page_cnt_q <= page_cnt_q + 8'h01;
              if (page_last_q) begin
                in_page_q <= 1'b0;
                page_cnt_q <= 8'h00;
                poll_first_q <= 1'b1;
                state_q <= USE_POLL ? S_POLL : S_WAIT;
              end else begin
                in_page_q <= 1'b1;
                state_q <= S_IDLE;
              end
            end else begin
              req_ready <= 1'b1;
              rsp_valid <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_WAIT: begin
          // no polling: sit out the whole write cycle
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q == WC_CYCLES + BLI_MAX) begin
            cnt_q <= 32'h0000_0000;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_POLL: begin
          // reads until two in a row show same bit six
          if (!poll_q) begin
            poll_q <= 1'b1;
            cur_wr_q <= 1'b0;
            cur_unl_q <= 1'b0;
            ce_n <= 1'b0;
            cnt_q <= 32'h0000_0000;
            state_q <= S_ALE;
          end else begin
            poll_q <= 1'b0;
            tog_q <= rsp_data[ewp_pkg::POLL_BIT];
            poll_first_q <= 1'b0;
            if (!poll_first_q &&
                rsp_data[ewp_pkg::POLL_BIT] == tog_q) begin
              busy <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // strobes never overlap, none during the latch strobe
  a_strobe_excl: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(!rd_n && !wr_n)) else $error("read and write strobes overlap");
  a_ale_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    ale |-> (rd_n && wr_n)) else $error("strobe during latch");
  a_data_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(wr_n) |-> ad_oe) else $error("data gone at write edge");
  a_unlock_first: assert property (@(posedge ref_clk)
    disable iff (!rstn)
    (state_q == S_IDLE && req_valid && req_write && !in_page_q && !req_ready)
      |=> cur_unl_q && cur_a_q == ewp_pkg::UNL_A0)
    else $error("write without unlock");
  // gap is cleared on the falling edge itself, so look one cycle back
  a_write_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(wr_n) |-> $past(gap_q) >= 32'(ewp_pkg::BLI_MIN_CYC))
    else $error("byte writes too close");
  // a page never grows past its byte limit
  a_page_limit: assert property (@(posedge ref_clk) disable iff (!rstn)
    page_cnt_q < 8'(ewp_pkg::PAGE_MAX)) else $error("page too long");
endmodule
`default_nettype wire

// ---- ewp_pkg.sv ----
// package: constants for the paged eeprom host controller
`default_nettype none
package ewp_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // bus strobe phase lengths in cycles (each phase 24 ns or more)
  localparam int unsigned T_PHASE_NS = 160;
  localparam int unsigned PHASE_CYC = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
  // byte load interval: least 0.5 us, most 100 us
  localparam int unsigned T_BLI_MIN_NS = 500;
  localparam int unsigned T_BLI_MAX_US = 100;
  localparam int unsigned BLI_MIN_CYC = (T_BLI_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLI_MAX_CYC = T_BLI_MAX_US * CLK_MHZ;
  // write cycle time, most 5 ms
  localparam int unsigned T_WC_MS = 5;
  localparam int unsigned WC_CYC = T_WC_MS * CLK_MHZ * 1000;
  localparam int unsigned PAGE_MAX = 128;
  localparam int unsigned POLL_BIT = 6;
  // unlock sequence: three address/data pairs
  localparam logic [14:0] UNL_A0 = 15'h5555;
  localparam logic [14:0] UNL_A1 = 15'h2AAA;
  localparam logic [14:0] UNL_A2 = 15'h5555;
  localparam logic [7:0] UNL_D0 = 8'hAA;
  localparam logic [7:0] UNL_D1 = 8'h55;
  localparam logic [7:0] UNL_D2 = 8'hA0;
  localparam logic [7:0] ADDR_LO_MASK = 8'h7F;
endpackage
`default_nettype wire

// ---- ewp_dev_model.sv ----
// behavioural model of the paged eeprom on the multiplexed bus
`default_nettype none
module ewp_dev_model #(
  parameter int unsigned LOAD_CYC = 400,
  parameter int unsigned BLI_MIN = 63
) (
  // time base only, the device itself has no clock
  input wire logic tick,
  input wire logic [31:0] prog_cyc,
  // bus pins
  input wire logic ale,
  input wire logic [14:8] addr_hi,
  input wire logic [7:0] ad,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ce_n,
  // read drive and observation
  output logic [7:0] dev_d,
  output logic dev_oe,
  output logic [31:0] spacing_err,
  output logic programming
);
  logic [7:0] mem [0:32767];
  logic [7:0] pend_d [0:127];
  logic [14:0] pend_a [0:127];
  logic [14:0] addr;
  int unsigned npend, unl, idle, left;
  logic tog;
  function automatic logic [22:0] ukey(int unsigned i);
    case (i)
      0: return {ewp_pkg::UNL_A0, ewp_pkg::UNL_D0};
      1: return {ewp_pkg::UNL_A1, ewp_pkg::UNL_D1};
      default: return {ewp_pkg::UNL_A2, ewp_pkg::UNL_D2};
    endcase
  endfunction
  task automatic start_prog();
    programming = 1'b1;
    left = prog_cyc;
  endtask
  // erased array, nothing pending
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {npend, unl, idle, left, spacing_err} = '0;
    {tog, dev_oe, programming, dev_d} = '0;
  end
  // full address taken on the falling latch strobe
  always @(negedge ale) addr = {addr_hi, ad};
  // each byte write restarts the load timer; too close is a host fault
  always @(negedge wr_n) if (!ce_n && !programming) begin
    if ((npend > 0 || unl > 0) && idle < BLI_MIN) spacing_err++;
    idle = 0;
  end
  // data only lands after the three unlock bytes, else ignored
  always @(posedge wr_n) if (!ce_n && !programming) begin
    if (unl == 3 && npend < 128) begin
      pend_a[npend] = addr;
      pend_d[npend] = ad;
      npend++;
    end else if (unl < 3 && {addr, ad} == ukey(unl)) unl++;
    else if (unl < 3) unl = 0;
  end
  // load window, then the self-timed cycle programs the page at once
  always @(posedge tick) begin
    if (programming && left > 1) left--;
    else if (programming) begin
      for (int i = 0; i < npend; i++) mem[pend_a[i]] = pend_d[i];
      {npend, unl} = '0;
      programming = 1'b0;
    end else if (idle < LOAD_CYC) idle++;
    else if (npend > 0) start_prog();
    else unl = 0;
  end
  // a read ends the load phase; bit six flips on every read meanwhile
  always @(negedge rd_n) if (!ce_n) begin
    if (npend > 0 && !programming) start_prog();
    tog = programming ? ~tog : tog;
    dev_d = programming ? {mem[addr][7], tog, mem[addr][5:0]} : mem[addr];
    dev_oe = 1'b1;
  end
  always @(posedge rd_n) dev_oe = 1'b0;
endmodule
`default_nettype wire

// ---- ewp_host_test.sv ----
// self-checking bench: host controller against the eeprom model
`default_nettype none
module ewp_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, req_valid, req_write, req_last, req_ready, rsp_valid;
  logic busy, ale, ad_oe, rd_n, wr_n, ce_n, pfs_n, dev_oe, programming;
  logic [14:0] req_addr;
  logic [14:8] addr_hi;
  logic [7:0] req_data, rsp_data, ad_o, dev_d, flt, ad_w;
  logic [7:0] exp_q[$];
  logic [7:0] shadow [int];
  int err_total, checks, cyc, n;
  int unsigned prog_cyc, spacing_err;
  logic [14:0] b;
  // released bus shows a changing pattern, never a held value
  assign ad_w = ad_oe ? ad_o : (dev_oe ? dev_d : flt);
  ewp_host #(.WC_CYCLES(4000), .BLI_MAX(400)) ewp_host_i (.ref_clk(ref_clk),
    .rstn(rstn), .clk_en(1'b1), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_data(req_data), .req_last(req_last),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .ale(ale), .addr_hi(addr_hi), .ad_o(ad_o), .ad_oe(ad_oe),
    .ad_i(ad_w), .rd_n(rd_n), .wr_n(wr_n), .ce_n(ce_n),
    .program_fetch_strobe_n(pfs_n));
  ewp_dev_model #(.LOAD_CYC(400)) ewp_dev_model_i (.tick(ref_clk),
    .prog_cyc(prog_cyc), .ale(ale), .addr_hi(addr_hi), .ad(ad_w),
    .rd_n(rd_n), .wr_n(wr_n), .ce_n(ce_n), .dev_d(dev_d), .dev_oe(dev_oe),
    .spacing_err(spacing_err), .programming(programming));
  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // request held until the ready pulse is sampled
  task automatic bus(logic wr, logic [14:0] a, logic [7:0] d, logic last);
    int k = 0;
    @(negedge ref_clk);
    {req_valid, req_write, req_addr, req_data, req_last} = {1'b1, wr, a, d, last};
    do begin
      @(posedge ref_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 20000);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(logic [14:0] a, logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00, 1'b0);
  endtask
  // write one page of random bytes, optionally wait for the host to settle
  task automatic page(logic [14:0] a, int cnt, int unsigned pc, bit hold);
    logic [7:0] d;
    prog_cyc = pc;
    for (int i = 0; i < cnt; i++) begin
      d = 8'($urandom);
      shadow[a + 15'(i)] = d;
      bus(1'b1, a + 15'(i), d, i == cnt - 1);
    end
    while (hold && (busy !== 1'b0 || programming !== 1'b0)) @(negedge ref_clk);
  endtask
  // floating bus pattern and run limit
  always @(posedge ref_clk) begin
    flt <= ~flt;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      $display("[ERR] run timed out");
      print_verdict();
    end
  end
  // read results and busy against the model's programming state
  // sampled on the falling edge, where outputs and the model are settled
  always @(negedge ref_clk) begin
    if (rstn && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra read", 8'h00, 8'h01);
      else check("read data", rsp_data, exp_q.pop_front());
    end
    if (programming === 1'b1) check("busy", {7'h0, busy}, 8'h01);
  end
  initial begin
    {rstn, req_valid, req_write, req_addr, req_data, req_last} = '0;
    {err_total, checks, cyc, prog_cyc} = '0;
    flt = 8'h5A;
    void'($urandom(91861));
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    page(15'h0100, 128, 40, 1'b1);
    for (int i = 0; i < 128; i++) rd(15'h0100 + 15'(i), shadow[256 + i]);
    $display("full page, prompt programming: done");
    n = 1 + $urandom % 8;
    b = {8'(8 + $urandom % 200), 7'h00};
    page(b, n, 3000, 1'b1);
    for (int i = 0; i <= n; i++) rd(b + 15'(i), i < n ? shadow[b + i] : 8'hFF);
    $display("short page, slow programming: done");
    page(b + 15'(n), 1, 1500, 1'b0);
    rd(b + 15'(n), shadow[b + n]);
    while (exp_q.size() != 0) @(negedge ref_clk);
    $display("read behind a single byte write: done");
    check("spacing faults", 8'(spacing_err), 8'h00);
    check("fetch strobe", {7'h0, pfs_n}, 8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
